// >>> logic/adc_select_top.sv
// adc_select_top: channel/reference register, conversion sequencing
// and result presentation of a 10-bit converter, behind an APB slave
// assumes analog levels arrive as synchronous millivolt words and the
// converter clock is a fixed division of ref_clk
// Function
// RQ1 - result stays in the result byte registers after completion
// RQ2 - single-ended code is input times 1024 over reference
// RQ3 - unipolar differential code is difference times 1024 times gain
// RQ4 - unipolar result is zero when negative input is higher
// RQ5 - differential is unipolar unless the bipolar bit is set
// RQ6 - bipolar code is difference times 512 times gain, two's complement
// RQ7 - result bit 9 is the sign in bipolar mode
// RQ8 - channel 1111 routes the temperature sensor single-ended
// RQ9 - three-bit reference field selects supply, pin, 1.1V or 2.56V
// RQ10 - reference field sits at bits 7:6 and 4, held during conversion
// RQ11 - a reference change lengthens the next conversion to 25 cycles
// RQ12 - left adjust at bit 5 changes the presented result at once
// RQ13 - channel field bits 3:0 held until the conversion completes
// RQ14 - codes 0-3 inputs, 1100 bandgap, 1101 ground, 1110 open
// RQ15 - codes 0100-1011 are differential pairs, odd codes gain 20
// RQ16 - codes 0100, 0101, 1000, 1001 short a pin for offset
// RQ17 - done flag sets when result registers are updated
// RQ18 - normal conversion 13 converter cycles, initialising one 25
// RQ19 - left adjust puts bits 9:2 high, right adjust bits 9:8 low
// RQ20 - channel/reference register resets to zero
`timescale 1ns/1ps
`default_nettype none
module adc_select_top #(
    parameter int VW      = 13,
    parameter int CLK_DIV = 2
) (
    // clock and reset
    input  wire logic           ref_clk,
    input  wire logic           reset,
    // apb slave
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic [7:0]     paddr,
    input  wire logic [31:0]    pwdata,
    input  wire logic [3:0]     pstrb,
    output logic      [31:0]    prdata,
    output logic                pready,
    output logic                pslverr,
    // sampled analog levels in millivolts
    input  wire logic [VW-1:0]  analog_input_0,
    input  wire logic [VW-1:0]  analog_input_1,
    input  wire logic [VW-1:0]  analog_input_2,
    input  wire logic [VW-1:0]  analog_input_3,
    input  wire logic [VW-1:0]  bandgap_voltage,
    input  wire logic [VW-1:0]  temp_sensor_voltage,
    input  wire logic [VW-1:0]  external_reference_pin,
    input  wire logic [VW-1:0]  supply_voltage,
    // analog control and status
    output adc_sel_pkg::refs_t  ref_select,
    output logic                ref_bypass_en,
    output logic                ext_ref_connect,
    output logic                temp_sensor_en,
    output logic                conv_busy,
    output logic                conversion_done_flag
);
    import adc_sel_pkg::*;
    localparam int DW = $clog2(CLK_DIV + 1);

    chan_ref_t     chan_ref_r;
    chan_ref_t     active_r;
    refs_t         last_ref_r;
    conv_state_t   state_r;
    logic          enable_r;
    logic          bipolar_r;
    logic          reverse_r;
    logic          flag_r;
    logic          init_pend_r;
    logic [4:0]    conv_len_r;
    logic [4:0]    conv_cnt_r;
    logic [DW-1:0] div_cnt_r;
    logic [9:0]    result_r;
    logic [31:0]   prdata_r;
    logic          wr_acc;
    logic          wr_chan;
    logic          wr_ctrl_a;
    logic          wr_ctrl_b;
    logic          enabling;
    logic          start_go;
    logic          long_nxt;
    logic          tick;
    logic          conv_end;
    logic [31:0]   rd_word;
    logic [VW-1:0] v_src [8];
    logic [VW-1:0] v_pos;
    logic [VW-1:0] v_neg;
    logic [VW-1:0] v_ref;
    route_t        route;
    logic [9:0]    code;

    // reference field gathered from its split positions
    function automatic refs_t refs_of(input chan_ref_t c);
        return {c.ref_hi, c.ref_lo};
    endfunction : refs_of

    function automatic logic addr_hit(input logic [7:0] a);
        return a == CHAN_REF_OFS || a == CTRL_A_OFS || a == CTRL_B_OFS ||
               a == RES_LOW_OFS || a == RES_HIGH_OFS;
    endfunction : addr_hit

    // RQ19 result placement in the two bytes
    function automatic logic [15:0] place(input logic [9:0] r,
                                          input logic left);
        return left ? {r, 6'h00} : {6'h00, r};
    endfunction : place

    // zero wait states; read data was captured in the setup cycle
    assign pready    = psel & penable;
    assign pslverr   = pready & ~addr_hit(paddr);
    assign prdata    = prdata_r;
    assign wr_acc    = pready & pwrite & pstrb[0];
    assign wr_chan   = wr_acc && paddr == CHAN_REF_OFS;
    assign wr_ctrl_a = wr_acc && paddr == CTRL_A_OFS;
    assign wr_ctrl_b = wr_acc && paddr == CTRL_B_OFS;

    // start needs the enable bit written in the same word; a held enable alone does not start
    assign enabling = wr_ctrl_a & pwdata[CA_EN_BIT] & ~enable_r;
    assign start_go = wr_ctrl_a & pwdata[CA_START_BIT] & pwdata[CA_EN_BIT]
                      & (state_r == ST_IDLE);
    // RQ11 RQ18 long after enable or a reference change
    assign long_nxt = init_pend_r | enabling |
                      (refs_of(chan_ref_r) != last_ref_r);

    // RQ20 RQ10 RQ12 channel/reference register
    always_ff @(posedge ref_clk) begin
        if (reset)
            chan_ref_r <= chan_ref_t'(CHAN_REF_RST);
        else if (wr_chan)
            chan_ref_r <= chan_ref_t'(pwdata[7:0]);
    end

    // RQ5 enable and mode bits, bipolar off after reset
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            enable_r  <= 1'b0;
            bipolar_r <= 1'b0;
            reverse_r <= 1'b0;
        end else begin
            if (wr_ctrl_a)
                enable_r <= pwdata[CA_EN_BIT];
            if (wr_ctrl_b) begin
                bipolar_r <= pwdata[CB_BIP_BIT];
                reverse_r <= pwdata[CB_IPR_BIT];
            end
        end
    end

    // first conversion after enabling initialises the converter
    always_ff @(posedge ref_clk) begin
        if (reset)
            init_pend_r <= 1'b0;
        else if (start_go)
            init_pend_r <= 1'b0;
        else if (enabling)
            init_pend_r <= 1'b1;
    end

    // RQ10 RQ13 channel/reference settings frozen while converting
    always_ff @(posedge ref_clk) begin
        if (reset)
            active_r <= chan_ref_t'(CHAN_REF_RST);
        else if (state_r == ST_IDLE)
            active_r <= chan_ref_r;
    end

    // RQ11 reference used by the previous conversion
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            last_ref_r <= refs_t'(CHAN_REF_RST[2:0]);
            conv_len_r <= CONV_NORMAL_CYC;
        end else if (start_go) begin
            last_ref_r <= refs_of(chan_ref_r);
            conv_len_r <= long_nxt ? CONV_INIT_CYC : CONV_NORMAL_CYC;
        end
    end

    // converter clock: one enable pulse every CLK_DIV cycles
    assign tick = (state_r == ST_CONV) && div_cnt_r == DW'(CLK_DIV - 1);
    always_ff @(posedge ref_clk) begin
        if (reset || state_r != ST_CONV || tick)
            div_cnt_r <= '0;
        else
            div_cnt_r <= div_cnt_r + 1'b1;
    end

    // RQ18 converter cycle count
    assign conv_end = enable_r && tick && conv_cnt_r == conv_len_r - 5'h01;
    always_ff @(posedge ref_clk) begin
        if (reset || state_r != ST_CONV)
            conv_cnt_r <= '0;
        else if (tick)
            conv_cnt_r <= conv_cnt_r + 5'h01;
    end

    // sequencing; clearing enable abandons a conversion
    always_ff @(posedge ref_clk) begin
        if (reset)
            state_r <= ST_IDLE;
        else
            case (state_r)
                ST_IDLE: if (start_go) state_r <= ST_CONV;
                ST_CONV: begin
                    if (!enable_r)
                        state_r <= ST_IDLE;
                    else if (conv_end)
                        state_r <= ST_DONE;
                end
                ST_DONE: state_r <= ST_IDLE;
                default: state_r <= ST_IDLE;
            endcase
    end

    // RQ1 result captured once, at the end of a conversion
    always_ff @(posedge ref_clk) begin
        if (reset)
            result_r <= '0;
        else if (state_r == ST_DONE)
            result_r <= code;
    end

    // RQ17 done flag; a completion beats a same-cycle clear
    always_ff @(posedge ref_clk) begin
        if (reset)
            flag_r <= 1'b0;
        else
            flag_r <= (state_r == ST_DONE) |
                      (flag_r & ~(wr_ctrl_a & pwdata[CA_FLAG_BIT]));
    end

    // read mux; unmapped offsets read zero
    always_comb begin
        rd_word = '0;
        case (paddr)
            CHAN_REF_OFS: rd_word[7:0] = chan_ref_r;
            CTRL_A_OFS: begin
                rd_word[CA_EN_BIT]    = enable_r;
                rd_word[CA_START_BIT] = conv_busy;
                rd_word[CA_FLAG_BIT]  = flag_r;
            end
            CTRL_B_OFS: begin
                rd_word[CB_BIP_BIT] = bipolar_r;
                rd_word[CB_IPR_BIT] = reverse_r;
            end
            // RQ12 adjust applied live to the stored result
            RES_LOW_OFS:
                rd_word[7:0] = 8'(place(result_r, chan_ref_r.left_adjust));
            RES_HIGH_OFS:
                rd_word = 32'(place(result_r, chan_ref_r.left_adjust) >> 8);
            default: rd_word = '0;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset)
            prdata_r <= '0;
        else if (psel && !penable && !pwrite)
            prdata_r <= rd_word;
    end

    // RQ9 reference decode, reserved code gives a zero reference
    always_comb begin
        case (refs_of(active_r))
            3'h0, 3'h4: v_ref = supply_voltage;
            3'h1, 3'h5: v_ref = external_reference_pin;
            REFS_INT11: v_ref = VW'(INT11_MV);
            3'h6, 3'h7: v_ref = VW'(INT256_MV);
            default:    v_ref = '0;
        endcase
    end

    assign ref_select      = refs_of(active_r);
    assign ref_bypass_en   = refs_of(active_r) == REFS_BYPASS;
    assign ext_ref_connect = active_r.ref_lo == 2'b01;
    assign conv_busy       = state_r != ST_IDLE;
    assign conversion_done_flag = flag_r;
    // RQ8 temperature sensor powered when routed
    assign temp_sensor_en  = route.pos == SRC_TEMP;

    assign v_src = '{analog_input_0, analog_input_1, analog_input_2,
                     analog_input_3, bandgap_voltage, {VW{1'b0}},
                     temp_sensor_voltage, {VW{1'b0}}};

    input_mux #(.VW(VW)) u_mux (
        .channel          (active_r.channel),
        .polarity_reverse (reverse_r),
        .v_src            (v_src),
        .route            (route),
        .v_pos            (v_pos),
        .v_neg            (v_neg)
    );

    code_former #(.VW(VW)) u_former (
        .v_pos   (v_pos),
        .v_neg   (v_neg),
        .v_ref   (v_ref),
        .diff    (route.diff),
        .gain20  (route.gain20),
        .bipolar (bipolar_r),
        .code    (code)
    );

    sequence conv_start_s;
        state_r == ST_IDLE && start_go;
    endsequence

    chk_init_length: assert property ( // RQ11
        @(posedge ref_clk) disable iff (reset)
        conv_start_s ##0 long_nxt |=> conv_len_r == 5'h19)
        else $error("long conversion not 25 cycles");
    chk_normal_length: assert property ( // RQ18
        @(posedge ref_clk) disable iff (reset)
        conv_start_s ##0 !long_nxt |=> conv_len_r == 5'h0D)
        else $error("normal conversion not 13 cycles");
    chk_channel_frozen: assert property ( // RQ13
        @(posedge ref_clk) disable iff (reset)
        state_r == ST_CONV |=> active_r.channel == $past(active_r.channel))
        else $error("channel changed during conversion");
    chk_ref_frozen: assert property ( // RQ10
        @(posedge ref_clk) disable iff (reset)
        state_r == ST_CONV ##1 state_r == ST_CONV |-> $stable(ref_select))
        else $error("reference changed during conversion");
    chk_flag_on_done: assert property ( // RQ17
        @(posedge ref_clk) disable iff (reset)
        state_r == ST_DONE |=> flag_r && result_r == $past(code))
        else $error("flag or result missing after completion");
    chk_result_held: assert property ( // RQ1
        @(posedge ref_clk) disable iff (reset)
        flag_r && state_r != ST_DONE |=> $stable(result_r))
        else $error("result changed without completion");
    chk_high_byte_adjust: assert property ( // RQ12
        @(posedge ref_clk) disable iff (reset)
        psel && !penable && !pwrite && paddr == RES_HIGH_OFS |=>
        prdata_r[7:0] == ($past(chan_ref_r.left_adjust) ?
            $past(result_r[9:2]) : {6'h00, $past(result_r[9:8])}))
        else $error("high byte not adjusted as selected");
    chk_unipolar_clamp: assert property ( // RQ4
        @(posedge ref_clk) disable iff (reset)
        route.diff && !bipolar_r && v_neg > v_pos |-> code == 10'h000)
        else $error("unipolar negative difference not zero");
    chk_sign_positive: assert property ( // RQ7
        @(posedge ref_clk) disable iff (reset)
        route.diff && bipolar_r && v_pos >= v_neg |-> !code[9])
        else $error("sign bit set for positive difference");
    chk_temp_route: assert property ( // RQ8
        @(posedge ref_clk) disable iff (reset)
        active_r.channel == CH_TEMP |-> temp_sensor_en && !route.diff)
        else $error("temperature channel not routed single-ended");
    chk_bypass_decode: assert property ( // RQ9
        @(posedge ref_clk) disable iff (reset)
        ref_bypass_en |-> ref_select == 3'h7 && v_ref == VW'(INT256_MV))
        else $error("bypass decode wrong");
endmodule : adc_select_top
`default_nettype wire

// >>> inc/adc_sel_pkg.sv
// package: register map, field layout, codes and cycle counts of the
// converter input select and result format block
// assumes a 32-bit APB slave on one clock and millivolt level inputs
package adc_sel_pkg;
    // register byte offsets
    localparam logic [7:0] CHAN_REF_OFS = 8'h00;
    localparam logic [7:0] CTRL_A_OFS   = 8'h04;
    localparam logic [7:0] CTRL_B_OFS   = 8'h08;
    localparam logic [7:0] RES_LOW_OFS  = 8'h0C;
    localparam logic [7:0] RES_HIGH_OFS = 8'h10;
    // reset values
    localparam logic [7:0] CHAN_REF_RST = 8'h00;
    // control bit positions
    localparam int CA_EN_BIT    = 7;
    localparam int CA_START_BIT = 6;
    localparam int CA_FLAG_BIT  = 4;
    localparam int CB_BIP_BIT   = 7;
    localparam int CB_IPR_BIT   = 5;
    // conversion lengths in converter clock cycles
    localparam logic [4:0] CONV_NORMAL_CYC = 5'h0D;
    localparam logic [4:0] CONV_INIT_CYC   = 5'h19;
    // result coding
    localparam int         UNI_SHIFT = 10;
    localparam int         BIP_SHIFT = 9;
    localparam int         GAIN_HIGH = 20;
    localparam logic [9:0] CODE_MAX  = 10'h3FF;
    localparam logic [9:0] BIP_MAX   = 10'h1FF;
    localparam logic [9:0] BIP_MIN   = 10'h200;
    // internal references in millivolts
    localparam int INT11_MV  = 1100;
    localparam int INT256_MV = 2560;
    // reference select codes
    typedef logic [2:0] refs_t;
    localparam refs_t REFS_INT11   = 3'h2;
    localparam refs_t REFS_BYPASS  = 3'h7;
    localparam logic [3:0] CH_TEMP = 4'hF;
    // channel/reference register layout
    typedef struct packed {
        logic [1:0] ref_lo;
        logic       left_adjust;
        logic       ref_hi;
        logic [3:0] channel;
    } chan_ref_t;
    typedef enum logic [2:0] {
        SRC_IN0, SRC_IN1, SRC_IN2, SRC_IN3,
        SRC_BANDGAP, SRC_GROUND, SRC_TEMP, SRC_NONE
    } src_t;
    typedef struct packed {
        src_t pos;
        src_t neg;
        logic diff;
        logic gain20;
    } route_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01,
        ST_DONE = 2'b11
    } conv_state_t;
endpackage : adc_sel_pkg

// >>> logic/input_mux.sv
// input_mux: decodes the channel field into a positive and negative
// source with gain, and picks the matching levels
// assumes levels are sampled words, synchronous to the block clock
`timescale 1ns/1ps
`default_nettype none
module input_mux #(
    parameter int VW = 13
) (
    // selection
    input  wire logic [3:0]         channel,
    input  wire logic               polarity_reverse,
    // levels indexed by source code
    input  wire logic [VW-1:0]      v_src [8],
    // routed result
    output adc_sel_pkg::route_t     route,
    output logic      [VW-1:0]      v_pos,
    output logic      [VW-1:0]      v_neg
);
    import adc_sel_pkg::*;

    // channel code to routing, pairs share gain on bit 0
    function automatic route_t decode(input logic [3:0] ch);
        route_t r;
        r = '{pos: SRC_NONE, neg: SRC_GROUND, diff: 1'b0, gain20: 1'b0};
        case (ch)
            4'h0, 4'h1, 4'h2, 4'h3: r.pos = src_t'({1'b0, ch[1:0]});
            4'h4, 4'h5: r = '{SRC_IN2, SRC_IN2, 1'b1, ch[0]};
            4'h6, 4'h7: r = '{SRC_IN2, SRC_IN3, 1'b1, ch[0]};
            4'h8, 4'h9: r = '{SRC_IN0, SRC_IN0, 1'b1, ch[0]};
            4'hA, 4'hB: r = '{SRC_IN0, SRC_IN1, 1'b1, ch[0]};
            4'hC: r.pos = SRC_BANDGAP;
            4'hD: r.pos = SRC_GROUND;
            4'hF: r.pos = SRC_TEMP;
            default: r.pos = SRC_NONE;
        endcase
        return r;
    endfunction : decode

    // ground and open inputs read as zero
    function automatic logic [VW-1:0] pick(input src_t s,
                                           input logic [VW-1:0] v [8]);
        return (s == SRC_GROUND || s == SRC_NONE) ? '0 : v[s];
    endfunction : pick

    // RQ14 RQ15 RQ16 channel and pair routing
    always_comb begin
        route = decode(channel);
        if (route.diff && polarity_reverse) begin
            v_pos = pick(route.neg, v_src);
            v_neg = pick(route.pos, v_src);
        end else begin
            v_pos = pick(route.pos, v_src);
            v_neg = pick(route.neg, v_src);
        end
    end
endmodule : input_mux
`default_nettype wire

// >>> logic/code_former.sv
// code_former: turns routed levels into the 10-bit result code for
// single-ended, unipolar and bipolar differential conversions
// assumes a reference level of zero means reserved, codes saturate
`timescale 1ns/1ps
`default_nettype none
module code_former #(
    parameter int VW = 13
) (
    // operands
    input  wire logic [VW-1:0] v_pos,
    input  wire logic [VW-1:0] v_neg,
    input  wire logic [VW-1:0] v_ref,
    input  wire logic          diff,
    input  wire logic          gain20,
    input  wire logic          bipolar,
    // result
    output logic      [9:0]    code
);
    import adc_sel_pkg::*;
    localparam int PW = VW + 15;

    // magnitude times 2^sh times gain over reference
    function automatic logic [PW-1:0] scale(input logic [VW-1:0] mag,
                                            input logic hi,
                                            input logic [VW-1:0] vr,
                                            input int sh);
        logic [PW-1:0] num;
        num = {{(PW-VW){1'b0}}, mag} << sh;
        if (hi) num = PW'(num * PW'(GAIN_HIGH));
        if (vr == '0) return '1;
        return num / {{(PW-VW){1'b0}}, vr};
    endfunction : scale

    logic          pos_ge;
    logic [VW-1:0] mag;
    logic [PW-1:0] q;

    // one path per conversion type; results beyond range saturate
    always_comb begin
        pos_ge = v_pos >= v_neg;
        mag    = pos_ge ? v_pos - v_neg : v_neg - v_pos;
        q      = '0;
        code   = '0;
        if (!diff) begin
            // RQ2 single-ended code
            q    = scale(v_pos, 1'b0, v_ref, UNI_SHIFT);
            code = (q > CODE_MAX) ? CODE_MAX : q[9:0];
        end else if (!bipolar) begin
            // RQ3 RQ4 unipolar, clamped at zero
            q    = scale(mag, gain20, v_ref, UNI_SHIFT);
            if (pos_ge) code = (q > CODE_MAX) ? CODE_MAX : q[9:0];
        end else begin
            // RQ6 RQ7 bipolar two's complement
            q = scale(mag, gain20, v_ref, BIP_SHIFT);
            if (pos_ge)
                code = (q > BIP_MAX) ? BIP_MAX : q[9:0];
            else if (q >= BIP_MIN)
                code = BIP_MIN;
            else
                code = 10'(-q[9:0]);
        end
    end
endmodule : code_former
`default_nettype wire

// >>> testbench/analog_far_side.sv
// analog_far_side: input levels seen by the converter
// assumes the bench loads one level per ref_clk edge
`timescale 1ns/1ps
`default_nettype none
module analog_far_side (
    // load port
    input  wire logic        ref_clk,
    input  wire logic        ld,
    input  wire logic [2:0]  ld_idx,
    input  wire logic [12:0] ld_val,
    // 0-3 pins, 4 bandgap, 5 sensor, 6 ext ref, 7 supply
    output logic      [12:0] lv [8]
);
    // a level holds until reloaded, like a slow source
    always_ff @(posedge ref_clk) begin
        if (ld) begin
            lv[ld_idx] <= ld_val;
        end
    end
endmodule : analog_far_side
`default_nettype wire

// >>> testbench/adc_input_select_result_format_test.sv
// adc_input_select_result_format_test: random and corner conversions
// assumes adc_select_top with CLK_DIV 2 and analog_far_side levels
`timescale 1ns/1ps
`default_nettype none
module adc_input_select_result_format_test;
    import adc_sel_pkg::*;
    logic        ref_clk, reset, psel, penable, pwrite, ld, pready;
    logic        pslverr, er, byp, extc, tsen, busy, flag;
    logic [7:0]  paddr, cr;
    logic [31:0] pwdata, prdata, rd;
    logic [12:0] ld_val, lv [8];
    logic [9:0]  x;
    logic [3:0]  c;
    logic [2:0]  ld_idx, md;
    refs_t       ref_select;
    int          err_count, n_compared, seed, n, p, m, v [8];
    logic [3:0]  chs [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hC, 4'hD, 4'hE, 4'hF};
    refs_t       rfs [6] = '{3'h1, 3'h2, 3'h6, 3'h7, 3'h3, 3'h0};

    adc_select_top #(.VW(13), .CLK_DIV(2)) u_adc_select_top (
        .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .analog_input_0(lv[0]), .analog_input_1(lv[1]),
        .analog_input_2(lv[2]), .analog_input_3(lv[3]),
        .bandgap_voltage(lv[4]), .temp_sensor_voltage(lv[5]),
        .external_reference_pin(lv[6]), .supply_voltage(lv[7]),
        .ref_select(ref_select), .ref_bypass_en(byp),
        .ext_ref_connect(extc), .temp_sensor_en(tsen),
        .conv_busy(busy), .conversion_done_flag(flag));
    analog_far_side u_analog_far_side (.ref_clk(ref_clk), .ld(ld),
        .ld_idx(ld_idx), .ld_val(ld_val), .lv(lv));

    // 200 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    // hang guard, well beyond some thirty conversions
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        close_out();
    end

    task automatic close_out();
        if (err_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED %0t seen %h exp %h", $time, s, e);
        end
    endtask : chk

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        if (!w) rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_idle();
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (busy === 1'b1 && n < 300);
    endtask : wait_idle

    // reference level for a select code; 011 reads as zero
    function automatic int vref(input refs_t r);
        case (r[1:0])
            2'b00: return v[7];
            2'b01: return v[6];
            default: return r[2] ? 2560 : (r[0] ? 0 : 1100);
        endcase
    endfunction : vref

    // ideal code; truncation toward zero gives truncation of the magnitude
    function automatic logic [9:0] code(input int p, input int m,
        input int r, input int g, input logic bi);
        int q;
        q = p - m;
        if (!bi && q < 0) q = 0;
        if (r == 0) q = q * 100000;
        else q = q * (bi ? 512 : 1024) * g / r;
        if (bi) q = q > 511 ? 511 : (q < -512 ? -512 : q);
        else if (q > 1023) q = 1023;
        return q[9:0];
    endfunction : code

    // full conversion: setup, start, length, flag, both result bytes
    task automatic conv(input logic [7:0] r, input logic [2:0] bi,
                        input int len, input logic [9:0] e);
        apb(1'b1, CTRL_B_OFS, 32'({bi, 5'h0}));
        apb(1'b1, CHAN_REF_OFS, 32'(r));
        apb(1'b1, CTRL_A_OFS, 32'hC0);
        wait_idle();
        chk(32'(n >= 2 * len && n <= 2 * len + 4), 32'h1);
        chk(32'(flag), 32'h1);
        apb(1'b1, CTRL_A_OFS, 32'h90);
        apb(1'b0, RES_LOW_OFS, 32'h0);
        chk(rd, 32'(r[5] ? {e[1:0], 6'h0} : e[7:0]));
        apb(1'b0, RES_HIGH_OFS, 32'h0);
        chk(rd, 32'(r[5] ? e[9:2] : e[9:8]));
        @(negedge ref_clk);
        chk(32'(flag), 32'h0);
    endtask : conv

    // main sequence
    initial begin
        {psel, penable, pwrite, ld, reset} = 5'h01;
        paddr = 8'h00;
        pwdata = 32'h0;
        ld_idx = 3'h0;
        ld_val = 13'h0;
        seed = 32'h100F0366;
        err_count = 0;
        n_compared = 0;
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        v[0] = 1 + $unsigned($random(seed)) % 3999;
        v[1] = v[0] + 700;
        v[2] = $unsigned($random(seed)) % 5000;
        v[3] = $unsigned($random(seed)) % 5000;
        v[4:7] = '{1100, 300, 2000, 5000};
        for (int i = 0; i < 8; i++) begin
            @(posedge ref_clk);
            ld <= 1'b1;
            ld_idx <= 3'(i);
            ld_val <= 13'(v[i]);
        end
        @(posedge ref_clk);
        ld <= 1'b0;
        apb(1'b0, CHAN_REF_OFS, 32'h0);
        chk(rd, 32'(CHAN_REF_RST));
        apb(1'b0, 8'h14, 32'h0);
        chk(32'(er), 32'h1);
        // every single-ended code, random adjust, supply reference
        for (int i = 0; i < 8; i++) begin
            cr = {2'b00, 1'($random(seed)), 1'b0, chs[i]};
            p = chs[i] < 4 ? v[chs[i]] : chs[i] == 12 ? v[4] :
                chs[i] == 15 ? v[5] : 0;
            x = code(p, 0, v[7], 1, 1'b0);
            conv(cr, 1'b0, i == 0 ? 25 : 13, x);
            chk(32'(tsen), 32'(chs[i] == CH_TEMP));
            apb(1'b1, CHAN_REF_OFS, 32'(cr ^ 8'h20));
            apb(1'b0, RES_HIGH_OFS, 32'h0);
            chk(rd, 32'(cr[5] ? x[9:8] : x[9:2]));
        end
        // six reference codes, 100 and 101 not used, each change costs a long conversion
        for (int i = 0; i < 6; i++) begin
            cr = {rfs[i][1:0], 1'b0, rfs[i][2], 4'h0};
            conv(cr, 1'b0, 25, code(v[0], 0, vref(rfs[i]), 1, 1'b0));
            chk(32'(ref_select), 32'(rfs[i]));
            chk(32'({byp, extc}),
                32'({rfs[i] == REFS_BYPASS, rfs[i][1:0] == 2'b01}));
        end
        // every differential code, unipolar then bipolar
        for (int i = 0; i < 16; i++) begin
            c = 4'(4 + i % 8);
            p = c[3] ? v[0] : v[2];
            m = c[1] ? (c[3] ? v[1] : v[3]) : p;
            // bipolar on the second pass, reversed pairs on upper codes
            md = 3'(i / 8 * 4 + i % 8 / 4);
            if (md[0]) {p, m} = {m, p};
            x = code(p, m, v[7], c[0] ? 20 : 1, md[2]);
            conv({4'h0, c}, md, 13, x);
            chk(32'(rd[1]), 32'(x[9]));
        end
        // settings written mid-conversion wait for its end
        apb(1'b1, CTRL_A_OFS, 32'hC0);
        apb(1'b1, CHAN_REF_OFS, 32'h4F);
        @(negedge ref_clk);
        chk(32'({busy, tsen, extc}), 32'h4);
        wait_idle();
        repeat (3) @(negedge ref_clk);
        chk(32'({tsen, extc}), 32'h3);
        close_out();
    end
endmodule : adc_input_select_result_format_test
`default_nettype wire
